// file: hdl/rsv_top.sv
// Ring signal validator: qualifies TIP/RING threshold events as a ring.
// Assumes events arrive as one-cycle pulses synchronous to clk_i.
//
// Overview of operation
// - Valid ring report waits a 3-bit delay code times 256 ms.
// - Ring ends after timeout code times 128 ms; code zero forbidden.
// - With enable set, ring valid only after frequency holds for the coded confirm time.
// - Enable clear bypasses validation; set runs qualify, confirm and delay.
// - Each event loads the qualify timer with the minimum-frequency field.
// - An event after the timer expired means too low; ring invalidated in qualify or delay, not once valid.
// - Events must be spaced at least min minus max field, in 2 ms.
//
// The AXI4-Lite slave port was chosen for this implementation.
`include "rsv_params.svh"

module rsv_top #(
  parameter int TICK_CYCLES = `RSV_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register bus
  input wire rsv_pkg::rsv_axi_req_s axi_req_i,
  output rsv_pkg::rsv_axi_rsp_s axi_rsp_o,
  // Line side
  input wire logic ring_evt_i,
  // Results
  output logic ring_valid_o,
  output logic irq_o
);

  // ----------------------------------------------------------------------
  // Constants and decoding
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_A = 3'h1;
  localparam logic [2:0] SEL_B = 3'h2;
  localparam logic [2:0] SEL_C = 3'h3;
  localparam logic [2:0] SEL_STAT = 3'h4;
  localparam logic [2:0] SEL_MASK = 3'h5;
  localparam logic [2:0] SEL_STATE = 3'h6;
  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);
  localparam logic [9:0] DLY_STEP = 10'(`RSV_DLY_STEP_MS / `RSV_TICK_MS);
  localparam logic [9:0] TO_STEP = 10'(`RSV_TO_STEP_MS / `RSV_TICK_MS);

  localparam rsv_pkg::rsv_state_s RST_Q = '{
    st: rsv_pkg::st_idle,
    ctrl_a: `RSV_CTRL_A_RESET,
    ctrl_b: `RSV_CTRL_B_RESET,
    ctrl_c: `RSV_CTRL_C_RESET,
    default: '0
  };

  // Byte address to register select
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    logic [2:0] sel;
    case (addr)
      8'(`RSV_IDX_CTRL_A << 2): sel = SEL_A;
      8'(`RSV_IDX_CTRL_B << 2): sel = SEL_B;
      8'(`RSV_IDX_CTRL_C << 2): sel = SEL_C;
      8'(`RSV_IDX_STATUS << 2): sel = SEL_STAT;
      8'(`RSV_IDX_MASK << 2): sel = SEL_MASK;
      8'(`RSV_IDX_STATE << 2): sel = SEL_STATE;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : reg_sel

  // Confirmation code to ticks of the 2 ms base
  function automatic logic [9:0] conf_ticks(input logic [2:0] code);
    logic [10:0] ms;
    case (code)
      3'h0: ms = 11'(`RSV_CONF_MS_0);
      3'h1: ms = 11'(`RSV_CONF_MS_1);
      3'h2: ms = 11'(`RSV_CONF_MS_2);
      3'h3: ms = 11'(`RSV_CONF_MS_3);
      3'h4: ms = 11'(`RSV_CONF_MS_4);
      3'h5: ms = 11'(`RSV_CONF_MS_5);
      3'h6: ms = 11'(`RSV_CONF_MS_6);
      default: ms = 11'(`RSV_CONF_MS_7);
    endcase
    return 10'(ms / 11'(`RSV_TICK_MS));
  endfunction : conf_ticks

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rsv_pkg::rsv_state_s q;
  rsv_pkg::rsv_state_s next_q;
  logic tick;
  logic en;
  logic bad;
  logic to_over;
  logic ev_valid;
  logic ev_end;
  logic ev_inv;
  logic rd_clr;
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic [5:0] min_freq;
  logic [5:0] min_space;
  logic [9:0] conf_tgt;
  logic [9:0] dly_tgt;
  logic [9:0] to_tgt;
  logic [31:0] rd_data;

  // Outputs straight from the state flops
  assign axi_rsp_o = q.rsp;
  assign ring_valid_o = q.ring_valid;
  assign irq_o = q.irq;
  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_q = q;
    ev_valid = 1'b0;
    ev_end = 1'b0;
    ev_inv = 1'b0;
    tick = (q.tick_cnt == TICK_LAST);
    next_q.tick_cnt = tick ? '0 : q.tick_cnt + 18'h1;
    // Write channel: take address and data together, answer next cycle
    wsel = reg_sel(axi_req_i.awaddr);
    next_q.rsp.awready = axi_req_i.awvalid && axi_req_i.wvalid &&
                         !q.rsp.awready && !q.rsp.bvalid;
    next_q.rsp.wready = next_q.rsp.awready;
    if (q.rsp.bvalid && axi_req_i.bready)
      next_q.rsp.bvalid = 1'b0;
    if (q.rsp.awready)
    begin
      next_q.rsp.bvalid = 1'b1;
      next_q.rsp.bresp = (wsel == SEL_NONE) ? `RSV_RESP_SLVERR
                                            : `RSV_RESP_OKAY;
      if (axi_req_i.wstrb[0])
      begin
        case (wsel)
          SEL_A: next_q.ctrl_a = axi_req_i.wdata[7:0];
          SEL_B: next_q.ctrl_b = axi_req_i.wdata[7:0];
          SEL_C:
          begin
            next_q.ctrl_c = axi_req_i.wdata[7:0];
            next_q.ctrl_c[`RSV_C_RSVD_BIT] = 1'b0;
          end
          SEL_MASK: next_q.mask = axi_req_i.wdata[2:0];
          default: ;
        endcase
      end
    end
    // Read channel: data is sampled at the address handshake
    rsel = reg_sel(axi_req_i.araddr);
    next_q.rsp.arready = axi_req_i.arvalid && !q.rsp.arready &&
                         !q.rsp.rvalid;
    case (rsel)
      SEL_A: rd_data = {24'h0, q.ctrl_a};
      SEL_B: rd_data = {24'h0, q.ctrl_b};
      SEL_C: rd_data = {24'h0, q.ctrl_c};
      SEL_STAT: rd_data = {29'h0, q.status};
      SEL_MASK: rd_data = {29'h0, q.mask};
      SEL_STATE: rd_data = {28'h0, q.st};
      default: rd_data = 32'h0;
    endcase
    rd_clr = q.rsp.arready && (rsel == SEL_STAT);
    if (q.rsp.rvalid && axi_req_i.rready)
      next_q.rsp.rvalid = 1'b0;
    if (q.rsp.arready)
    begin
      next_q.rsp.rvalid = 1'b1;
      next_q.rsp.rdata = rd_data;
      next_q.rsp.rresp = (rsel == SEL_NONE) ? `RSV_RESP_SLVERR
                                            : `RSV_RESP_OKAY;
    end
    // Decoded configuration
    en = q.ctrl_c[`RSV_C_EN_BIT];
    min_freq = q.ctrl_c[`RSV_C_MINF_LSB +: 6];
    // least event spacing; max bound must stay below the load
    min_space = min_freq - q.ctrl_a[`RSV_A_MAXF_LSB +: 6];
    conf_tgt = conf_ticks(q.ctrl_b[`RSV_B_CONF_LSB +: 3]);
    dly_tgt = 10'({q.ctrl_b[`RSV_B_DLY2_BIT],
                   q.ctrl_a[`RSV_A_DLY_LSB +: 2]} * DLY_STEP);
    // timeout measured from the latest event
    to_tgt = 10'(q.ctrl_b[`RSV_B_TO_LSB +: 4] * TO_STEP);
    to_over = (q.to_cnt >= to_tgt);
    // timer expired or events too close
    bad = (q.qual_tmr == 6'h0) || (q.space_cnt < min_space);
    // Free-running timers while a ring is in progress
    if (tick && q.st != rsv_pkg::st_idle)
    begin
      if (q.qual_tmr != 6'h0)
        next_q.qual_tmr = q.qual_tmr - 6'h1;
      if (q.space_cnt != 6'h3f)
        next_q.space_cnt = q.space_cnt + 6'h1;
      if (q.to_cnt != 10'h3ff)
        next_q.to_cnt = q.to_cnt + 10'h1;
    end
    if (ring_evt_i)
    begin
      // reload qualify timer on every event
      next_q.qual_tmr = min_freq;
      next_q.space_cnt = '0;
      next_q.to_cnt = '0;
    end
    // Ring qualification sequence
    case (q.st)
      rsv_pkg::st_idle:
      begin
        if (ring_evt_i)
        begin
          next_q.conf_cnt = '0;
          // bypass reports at once when disabled
          if (en)
            next_q.st = rsv_pkg::st_qual;
          else
          begin
            next_q.st = rsv_pkg::st_valid;
            ev_valid = 1'b1;
          end
        end
      end
      rsv_pkg::st_qual, rsv_pkg::st_delay:
      begin
        if (!en)
        begin
          next_q.st = rsv_pkg::st_valid;
          ev_valid = 1'b1;
        end
        else if (ring_evt_i && bad)
        begin
          // invalidate and restart on a bad event
          ev_inv = 1'b1;
          next_q.st = rsv_pkg::st_qual;
          next_q.conf_cnt = '0;
        end
        else if (!ring_evt_i && to_over)
          next_q.st = rsv_pkg::st_idle;
        else if (q.st == rsv_pkg::st_qual)
        begin
          // confirm time must pass with good spacing
          if (q.qual_tmr == 6'h0) // Rate fell below the window
            next_q.conf_cnt = '0;
          else if (q.conf_cnt >= conf_tgt)
          begin
            next_q.st = rsv_pkg::st_delay;
            next_q.dly_cnt = '0;
          end
          else if (tick)
            next_q.conf_cnt = q.conf_cnt + 10'h1;
        end
        else
        begin
          if (q.dly_cnt >= dly_tgt)
          begin
            next_q.st = rsv_pkg::st_valid;
            ev_valid = 1'b1;
          end
          else if (tick)
            next_q.dly_cnt = q.dly_cnt + 10'h1;
        end
      end
      rsv_pkg::st_valid:
      begin
        // ring over once the timeout elapses
        if (!ring_evt_i && to_over)
        begin
          next_q.st = rsv_pkg::st_idle;
          ev_end = 1'b1;
        end
      end
      default: next_q.st = rsv_pkg::st_idle;
    endcase
    // events set sticky status; a new event beats read-clear
    next_q.valid_pls = ev_valid;
    next_q.status = (rd_clr ? 3'h0 : q.status) | {ev_inv, ev_end, ev_valid};
    next_q.irq = |(next_q.status & next_q.mask);
    next_q.ring_valid = (next_q.st == rsv_pkg::st_valid);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // reset clears every timer
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      q <= RST_Q;
    else
      q <= next_q;
  end
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  a_delay_to_valid: assert property (
    q.st == rsv_pkg::st_delay && en && !ring_evt_i && !to_over &&
    q.dly_cnt >= dly_tgt |=> q.st == rsv_pkg::st_valid && q.valid_pls)
    else $error("delay done but ring not reported");
  a_timeout_end: assert property (
    q.st == rsv_pkg::st_valid && !ring_evt_i && q.to_cnt >= to_tgt
    |=> q.st == rsv_pkg::st_idle && q.status[`RSV_ST_END_BIT])
    else $error("timeout did not end the ring");
  a_confirm_time: assert property (
    q.st == rsv_pkg::st_qual ##1 q.st == rsv_pkg::st_delay
    |-> $past(q.conf_cnt) >= $past(conf_tgt))
    else $error("ring confirmed early");
  a_bypass_direct: assert property (
    q.st == rsv_pkg::st_idle && !en && ring_evt_i
    |=> q.ring_valid && q.valid_pls)
    else $error("bypass did not report ring");
  a_reserved_zero: assert property (
    q.ctrl_c[`RSV_C_RSVD_BIT] == 1'b0)
    else $error("reserved bit set");
  a_timer_load: assert property (
    ring_evt_i |=> q.qual_tmr == $past(min_freq) && q.space_cnt == 6'h0)
    else $error("qualify timer not loaded");
  a_low_freq: assert property (
    q.st == rsv_pkg::st_qual && en && ring_evt_i && q.qual_tmr == 6'h0
    |=> q.status[`RSV_ST_INV_BIT] && q.conf_cnt == 10'h0)
    else $error("late event not invalidated");
  a_high_freq: assert property (
    q.st == rsv_pkg::st_qual && en && ring_evt_i && q.space_cnt < min_space
    |=> q.st == rsv_pkg::st_qual && q.status[`RSV_ST_INV_BIT])
    else $error("close event not invalidated");
  a_valid_pulse: assert property (
    q.valid_pls |=> !q.valid_pls)
    else $error("valid indication longer than one cycle");
  a_irq_level: assert property (
    irq_o == |(q.status & q.mask))
    else $error("interrupt does not follow status");

endmodule : rsv_top

// file: inc/rsv_params.svh
// Constants for the ring signal validator: offsets, fields, resets, timing.
// Assumes a 125 MHz system clock and an AXI4-Lite register bus.
`ifndef RSV_PARAMS_SVH
`define RSV_PARAMS_SVH

// Clock and time base
`define RSV_CLK_MHZ 125
`define RSV_TICK_MS 2
`define RSV_TICK_CYCLES (`RSV_TICK_MS * 1000 * `RSV_CLK_MHZ)
`define RSV_TICK_W 18
`define RSV_DLY_STEP_MS 256
`define RSV_TO_STEP_MS 128
`define RSV_CONF_MS_0 100
`define RSV_CONF_MS_1 150
`define RSV_CONF_MS_2 200
`define RSV_CONF_MS_3 256
`define RSV_CONF_MS_4 384
`define RSV_CONF_MS_5 512
`define RSV_CONF_MS_6 640
`define RSV_CONF_MS_7 1024

// Register indices; byte address is four times the index
`define RSV_IDX_CTRL_A 8'h16
`define RSV_IDX_CTRL_B 8'h17
`define RSV_IDX_CTRL_C 8'h18
`define RSV_IDX_STATUS 8'h20
`define RSV_IDX_MASK 8'h21
`define RSV_IDX_STATE 8'h22

// Reset values
`define RSV_CTRL_A_RESET 8'h00
`define RSV_CTRL_B_RESET 8'h08
`define RSV_CTRL_C_RESET 8'h19

// Field positions
`define RSV_A_MAXF_LSB 0
`define RSV_A_DLY_LSB 6
`define RSV_B_CONF_LSB 0
`define RSV_B_TO_LSB 3
`define RSV_B_DLY2_BIT 7
`define RSV_C_MINF_LSB 0
`define RSV_C_RSVD_BIT 6
`define RSV_C_EN_BIT 7
`define RSV_ST_VALID_BIT 0
`define RSV_ST_END_BIT 1
`define RSV_ST_INV_BIT 2

// Bus responses
`define RSV_RESP_OKAY 2'h0
`define RSV_RESP_SLVERR 2'h2

`endif

// file: inc/rsv_pkg.sv
// Types for the ring signal validator: FSM states, bus carriers, state.
// Assumes rsv_params.svh supplies the numeric constants.
package rsv_pkg;

  typedef enum logic [3:0] {
    st_idle  = 4'h1,
    st_qual  = 4'h2,
    st_delay = 4'h4,
    st_valid = 4'h8
  } rsv_state_e;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } rsv_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsv_axi_rsp_s;

  typedef struct packed {
    rsv_state_e st;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [2:0] status;
    logic [2:0] mask;
    logic [17:0] tick_cnt;
    logic [5:0] qual_tmr;
    logic [5:0] space_cnt;
    logic [9:0] conf_cnt;
    logic [9:0] dly_cnt;
    logic [9:0] to_cnt;
    logic valid_pls;
    logic ring_valid;
    logic irq;
    rsv_axi_rsp_s rsp;
  } rsv_state_s;

endpackage : rsv_pkg

// file: tb/rsv_line_model.sv
// ----------------------------------------
// Line-side partner: TIP/RING threshold events
// ----------------------------------------
// Assumes go_i is a one-cycle pulse; gap_i counts 2 ms ticks.
module rsv_line_model #(
  parameter int TICK = 4
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] gap_i,
  input wire logic [7:0] num_i,
  // Line side
  output logic ring_evt_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Event train, one-cycle pulses, line idles low
  initial
  begin
    ring_evt_o = 1'b0;
    busy_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (go_i)
      begin
        busy_o <= 1'b1;
        repeat (num_i)
        begin
          ring_evt_o <= 1'b1;
          @(posedge clk_i);
          ring_evt_o <= 1'b0;
          repeat (gap_i * TICK - 1) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule : rsv_line_model

// file: tb/tb_top.sv
// ----------------------------------------
// Self-checking bench for the ring validator
// ----------------------------------------
// Assumes a short prescaler: one 2 ms tick is TK clock cycles.
`include "rsv_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  localparam logic [7:0] CA = `RSV_IDX_CTRL_A * 8'h04;
  localparam logic [7:0] CB = `RSV_IDX_CTRL_B * 8'h04;
  localparam logic [7:0] CC = `RSV_IDX_CTRL_C * 8'h04;
  localparam logic [7:0] ST = `RSV_IDX_STATUS * 8'h04;
  localparam logic [7:0] MK = `RSV_IDX_MASK * 8'h04;
  localparam logic [7:0] SS = `RSV_IDX_STATE * 8'h04;
  localparam logic [1:0] OK = `RSV_RESP_OKAY;
  localparam logic [1:0] ER = `RSV_RESP_SLVERR;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  rsv_pkg::rsv_axi_req_s req = '0;
  rsv_pkg::rsv_axi_rsp_s rsp;
  logic ring_evt, ring_valid, irq, busy;
  logic go = 1'b0;
  logic [7:0] gap = 8'h01;
  logic [7:0] num = 8'h01;
  logic [7:0] r;
  logic [33:0] rq[$];
  logic [1:0] wq[$];
  int errors = 0;
  int cmp_count = 0;
  int g;

  // Clock, 8 ns period
  always #4 clk_i = ~clk_i;

  rsv_top #(.TICK_CYCLES(TK)) dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .axi_req_i(req), .axi_rsp_o(rsp), .ring_evt_i(ring_evt),
    .ring_valid_o(ring_valid), .irq_o(irq));
  rsv_line_model #(.TICK(TK)) line_u (.clk_i(clk_i), .go_i(go),
    .gap_i(gap), .num_i(num), .ring_evt_o(ring_evt), .busy_o(busy));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Watcher takes the oldest note whenever a response is handed over
  always @(posedge clk_i)
  begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
      chk({rsp.rresp, rsp.rdata}, rq.pop_front());
    if (rsp.bvalid === 1'b1 && req.bready === 1'b1)
      chk({32'h0, rsp.bresp}, {32'h0, wq.pop_front()});
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    wq.push_back(e);
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do @(posedge clk_i); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    while (rsp.bvalid !== 1'b1) @(posedge clk_i);
    req.bready <= 1'b0;
    // Let an edge pass before the next request
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    rq.push_back({e, 24'h0, d});
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge clk_i); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    while (rsp.rvalid !== 1'b1) @(posedge clk_i);
    req.rready <= 1'b0;
    // Let an edge pass before the next request
    @(posedge clk_i);
  endtask : rd

  task automatic wt(input int t);
    repeat (t * TK) @(posedge clk_i);
  endtask : wt

  task automatic fire(input int gp, input int n);
    gap <= 8'(gp);
    num <= 8'(n);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask : fire

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // Watchdog, several times the expected run of about 4100 cycles
  initial
  begin
    repeat (40000) @(posedge clk_i);
    errors++;
    print_verdict();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(74662));
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(CA, `RSV_CTRL_A_RESET, OK);
    rd(CB, `RSV_CTRL_B_RESET, OK);
    rd(CC, `RSV_CTRL_C_RESET, OK);
    rd(SS, 8'h01, OK);
    r = 8'($urandom);
    wr(CA, r, OK);
    rd(CA, r, OK);
    // reserved bit zero, timer covers lowest rate
    wr(CC, 8'h8c, OK);
    rd(CC, 8'h8c, OK);
    wr(CB, 8'h10, OK);
    wr(CA, 8'h04, OK);
    wr(MK, 8'h02, OK);
    $display("test registers done");
    g = 9 + int'($urandom % 3);
    fire(g, 12);
    wt(40);
    rd(SS, 8'h02, OK);
    wt(40);
    rd(SS, 8'h08, OK);
    chk({33'h0, ring_valid}, 34'h1);
    wait (busy === 1'b0);
    wt(122 - g);
    rd(SS, 8'h08, OK);
    wt(12);
    rd(SS, 8'h01, OK);
    chk({33'h0, irq}, 34'h1);
    rd(ST, 8'h03, OK);
    repeat (3) @(posedge clk_i);
    chk({33'h0, irq}, 34'h0);
    $display("test valid ring done");
    wr(CA, 8'h44, OK);
    fire(10, 22);
    wt(120);
    rd(SS, 8'h04, OK);
    wt(80);
    rd(SS, 8'h08, OK);
    wait (busy === 1'b0);
    wt(140);
    rd(ST, 8'h03, OK);
    $display("test delay done");
    wr(CA, 8'h04, OK);
    fire(20, 3);
    wt(70);
    rd(ST, 8'h04, OK);
    wt(150);
    rd(SS, 8'h01, OK);
    fire(3, 4);
    wt(20);
    rd(ST, 8'h04, OK);
    wt(150);
    $display("test invalid rings done");
    wr(MK, 8'h01, OK);
    wr(CC, 8'h0c, OK);
    chk({33'h0, irq}, 34'h0);
    fire(1, 1);
    wt(1);
    chk({33'h0, ring_valid}, 34'h1);
    chk({33'h0, irq}, 34'h1);
    rd(ST, 8'h01, OK);
    repeat (3) @(posedge clk_i);
    chk({33'h0, irq}, 34'h0);
    // Unmapped place refused without effect
    wr(8'hfc, 8'h55, ER);
    rd(8'hfc, 8'h00, ER);
    rd(CA, 8'h04, OK);
    $display("test bypass and bus done");
    print_verdict();
  end
endmodule : tb_top
